// >>> debug_port_control_registers.v
// Register bank of the single-wire debug port physical and access layers
`include "dbg_port_map.vh"
module debug_port_control_registers #(
    parameter [3:0] IMPL_REVISION = 4'h2,
    parameter TIMEOUT_LIMIT = `TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Debugger register port, serial instruction side
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [3:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    output reg o_reg_rvalid,
    // Physical layer error events
    input wire i_err_parity,
    input wire i_err_frame,
    input wire i_err_clock_recovery,
    input wire i_err_contention,
    // Access layer handshake
    input wire i_acc_wait,
    // Transmit byte context
    input wire i_tx_first_byte,
    input wire i_sys_reset_during_access,
    // Key events
    input wire i_user_row_key_set,
    input wire i_user_row_key_clr,
    input wire i_program_key_set,
    input wire i_program_done,
    input wire i_erase_key_set,
    input wire i_erase_done,
    // Physical layer configuration
    output reg o_inter_byte_delay_en,
    output reg o_parity_check_off,
    output reg o_timeout_detect_off,
    output reg o_response_sig_off,
    output reg [2:0] o_guard_time_sel,
    output reg [7:0] o_guard_cycles,
    output reg [1:0] o_idle_chars,
    output reg o_neg_ack_en,
    output reg o_contention_detect_off,
    output reg [1:0] o_link_clock_select,
    // Status and system outputs
    output reg o_interface_reset,
    output reg o_clock_request,
    output reg o_timeout_err,
    output reg o_system_reset
);
    reg [7:0] ctrl_first_reg;
    reg [7:0] ctrl_first_next;
    reg [2:0] ctrl_second_reg;
    reg [2:0] ctrl_second_next;
    reg [2:0] error_signature_reg;
    reg [2:0] error_signature_next;
    reg user_row_key_active_reg;
    reg program_key_active_reg;
    reg erase_key_active_reg;
    reg system_reset_reg;
    reg [1:0] clock_sel_reg;
    reg [7:0] rdata_next;
    reg disable_reg;
    wire [7:0] guard_cycles;
    wire [1:0] idle_chars;
    wire timeout_hit;
    wire [3:0] sync_in;
    reg [3:0] sync1_reg;
    reg [3:0] sync2_reg;
    wire if_rst;

    ////////////////////////////////////////////////////////////////////////
    // Interface reset: external reset or interface disable
    assign if_rst = i_rst || disable_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pin-side error inputs pass two flip-flops
    assign sync_in = {i_err_contention, i_err_clock_recovery, i_err_frame, i_err_parity};
    always @(posedge i_clk) begin
        if (i_rst) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= sync_in;
            sync2_reg <= sync1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    guard_time_gen u_guard (
        .i_guard_sel(ctrl_first_reg[2:0]),
        .i_first_byte(i_tx_first_byte),
        .i_ibd_en(ctrl_first_reg[`BIT_INTER_BYTE_DELAY]),
        .o_guard_cycles(guard_cycles),
        .o_idle_chars(idle_chars)
    );

    timeout_counter #(
        .LIMIT(TIMEOUT_LIMIT)
    ) u_timeout (
        .i_clk(i_clk),
        .i_rst(if_rst),
        .i_wait(i_acc_wait),
        .i_off(ctrl_first_reg[`BIT_TIMEOUT_OFF]),
        .o_expired(timeout_hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write decode
    always @* begin
        ctrl_first_next = ctrl_first_reg;
        ctrl_second_next = ctrl_second_reg;
        if (i_reg_wr && i_reg_addr == `OFS_LINK_CTRL_FIRST) begin
            ctrl_first_next = {i_reg_wdata[7], 1'b0, i_reg_wdata[5:0]};
        end
        if (i_reg_wr && i_reg_addr == `OFS_LINK_CTRL_SECOND) begin
            ctrl_second_next = i_reg_wdata[4:2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error signature: new error wins over read clear
    always @* begin
        error_signature_next = error_signature_reg;
        if (i_reg_rd && i_reg_addr == `OFS_ERROR_SIG_STATUS) begin
            error_signature_next = `SIG_NONE;
        end
        if (sync2_reg[3] && !ctrl_second_reg[1]) begin
            error_signature_next = `SIG_CONTENTION;
        end else if (timeout_hit) begin
            error_signature_next = `SIG_TIMEOUT;
        end else if (sync2_reg[2]) begin
            error_signature_next = `SIG_CLOCK_RECOVERY;
        end else if (sync2_reg[1]) begin
            error_signature_next = `SIG_FRAME;
        end else if (sync2_reg[0] && !ctrl_first_reg[`BIT_PARITY_OFF]) begin
            error_signature_next = `SIG_PARITY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration and error state, reset with the interface
    always @(posedge i_clk) begin
        if (if_rst) begin
            ctrl_first_reg <= `RST_LINK_CTRL;
            ctrl_second_reg <= 3'h0;
            error_signature_reg <= `RST_ERROR_SIG;
            clock_sel_reg <= `RST_CLOCK_SEL;
            user_row_key_active_reg <= 1'b0;
            program_key_active_reg <= 1'b0;
            erase_key_active_reg <= 1'b0;
        end else begin
            ctrl_first_reg <= ctrl_first_next;
            ctrl_second_reg <= ctrl_second_next;
            error_signature_reg <= error_signature_next;
            if (i_reg_wr && i_reg_addr == `OFS_LINK_CLOCK_SEL && i_reg_wdata[1:0] != 2'h0) begin
                clock_sel_reg <= i_reg_wdata[1:0];
            end
            if (i_user_row_key_set) begin
                user_row_key_active_reg <= 1'b1;
            end else if (i_user_row_key_clr) begin
                user_row_key_active_reg <= 1'b0;
            end
            if (i_program_key_set) begin
                program_key_active_reg <= 1'b1;
            end else if (i_program_done) begin
                program_key_active_reg <= 1'b0;
            end
            if (i_erase_key_set) begin
                erase_key_active_reg <= 1'b1;
            end else if (i_erase_done) begin
                erase_key_active_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Disable pulse and system reset request
    always @(posedge i_clk) begin
        if (i_rst) begin
            disable_reg <= 1'b0;
        end else begin
            disable_reg <= !disable_reg && ctrl_second_reg[0];
        end
    end

    always @(posedge i_clk) begin
        if (if_rst) begin
            system_reset_reg <= 1'b0;
        end else if (i_reg_wr && i_reg_addr == `OFS_SYS_RESET_REQ) begin
            system_reset_reg <= (i_reg_wdata == `RESET_REQ_CODE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path, debugger port only
    always @* begin
        rdata_next = 8'h00;
        case (i_reg_addr)
            `OFS_REVISION_STATUS: rdata_next = {IMPL_REVISION, 4'h0};
            `OFS_ERROR_SIG_STATUS: rdata_next = {5'h00, error_signature_reg};
            `OFS_LINK_CTRL_FIRST: rdata_next = ctrl_first_reg;
            `OFS_LINK_CTRL_SECOND: rdata_next = {3'h0, ctrl_second_reg, 2'h0};
            `OFS_KEY_ACTIVE_STATUS: rdata_next = {2'h0, user_row_key_active_reg,
                program_key_active_reg, erase_key_active_reg, 3'h0};
            `OFS_SYS_RESET_REQ: rdata_next = {7'h00, system_reset_reg};
            `OFS_LINK_CLOCK_SEL: rdata_next = {6'h00, clock_sel_reg};
            default: rdata_next = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
            o_inter_byte_delay_en <= 1'b0;
            o_parity_check_off <= 1'b0;
            o_timeout_detect_off <= 1'b0;
            o_response_sig_off <= 1'b0;
            o_guard_time_sel <= 3'h0;
            o_guard_cycles <= `GUARD_BASE_CYCLES;
            o_idle_chars <= 2'h0;
            o_neg_ack_en <= 1'b0;
            o_contention_detect_off <= 1'b0;
            o_link_clock_select <= `RST_CLOCK_SEL;
            o_interface_reset <= 1'b1;
            o_clock_request <= 1'b0;
            o_timeout_err <= 1'b0;
            o_system_reset <= 1'b0;
        end else begin
            o_reg_rdata <= i_reg_rd ? rdata_next : 8'h00;
            o_reg_rvalid <= i_reg_rd;
            o_inter_byte_delay_en <= ctrl_first_reg[`BIT_INTER_BYTE_DELAY];
            o_parity_check_off <= ctrl_first_reg[`BIT_PARITY_OFF];
            o_timeout_detect_off <= ctrl_first_reg[`BIT_TIMEOUT_OFF];
            o_response_sig_off <= ctrl_first_reg[`BIT_RESP_SIG_OFF];
            o_guard_time_sel <= ctrl_first_reg[2:0];
            o_guard_cycles <= guard_cycles;
            o_idle_chars <= idle_chars;
            o_neg_ack_en <= i_sys_reset_during_access && !ctrl_second_reg[2];
            o_contention_detect_off <= ctrl_second_reg[1];
            o_link_clock_select <= clock_sel_reg;
            o_interface_reset <= if_rst;
            o_clock_request <= !if_rst;
            o_timeout_err <= timeout_hit;
            o_system_reset <= system_reset_reg && !if_rst;
        end
    end
endmodule

// >>> dbg_port_map.vh
// Register map and timing constants of the debug port control registers
`ifndef DBG_PORT_MAP_VH
`define DBG_PORT_MAP_VH
`define OFS_REVISION_STATUS 4'h0
`define OFS_ERROR_SIG_STATUS 4'h1
`define OFS_LINK_CTRL_FIRST 4'h2
`define OFS_LINK_CTRL_SECOND 4'h3
`define OFS_KEY_ACTIVE_STATUS 4'h7
`define OFS_SYS_RESET_REQ 4'h8
`define OFS_LINK_CLOCK_SEL 4'h9
`define OFS_LAST 4'hC
`define BIT_INTER_BYTE_DELAY 7
`define BIT_PARITY_OFF 5
`define BIT_TIMEOUT_OFF 4
`define BIT_RESP_SIG_OFF 3
`define BIT_NEG_ACK_OFF 4
`define BIT_CONTENTION_OFF 3
`define BIT_INTERFACE_OFF 2
`define BIT_USER_ROW_KEY 5
`define BIT_PROGRAM_KEY 4
`define BIT_ERASE_KEY 3
`define RST_LINK_CTRL 8'h00
`define RST_ERROR_SIG 3'h0
`define RST_CLOCK_SEL 2'h3
`define RESET_REQ_CODE 8'h59
`define SIG_NONE 3'h0
`define SIG_PARITY 3'h1
`define SIG_FRAME 3'h2
`define SIG_TIMEOUT 3'h3
`define SIG_CLOCK_RECOVERY 3'h4
`define SIG_CONTENTION 3'h7
`define GUARD_OFF_SEL 3'h7
`define GUARD_BASE_CYCLES 8'h80
`define TIMEOUT_CYCLES 65536
`define IDLE_CHARS_BETWEEN 2'h2
`endif

// >>> guard_time_gen.v
// Guard time and inter-byte delay length selection
`include "dbg_port_map.vh"
module guard_time_gen (
    // Configuration
    input wire [2:0] i_guard_sel,
    input wire i_first_byte,
    input wire i_ibd_en,
    // Result
    output wire [7:0] o_guard_cycles,
    output wire [1:0] o_idle_chars
);
    assign o_guard_cycles = (i_guard_sel == `GUARD_OFF_SEL) ? 8'h00 :
        (`GUARD_BASE_CYCLES >> i_guard_sel);
    assign o_idle_chars = (i_ibd_en && !i_first_byte) ? `IDLE_CHARS_BETWEEN : 2'h0;
endmodule

// >>> timeout_counter.v
// Access-layer response time-out counter
`include "dbg_port_map.vh"
module timeout_counter #(
    parameter LIMIT = `TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Control
    input wire i_wait,
    input wire i_off,
    // Result
    output reg o_expired
);
    reg [16:0] count_reg;
    always @(posedge i_clk) begin
        if (i_rst || !i_wait || i_off) begin
            count_reg <= 17'h0_0000;
            o_expired <= 1'b0;
        end else begin
            if (count_reg == LIMIT[16:0] - 17'h0_0001) begin
                o_expired <= 1'b1;
            end else begin
                o_expired <= 1'b0;
            end
            if (count_reg != LIMIT[16:0]) begin
                count_reg <= count_reg + 17'h0_0001;
            end
        end
    end
endmodule

// >>> debug_port_control_registers_chk.sv
// Assertion checker for the debug port register bank
module debug_port_control_registers_chk #(
    parameter [3:0] IMPL_REVISION = 4'h2,
    parameter TIMEOUT_LIMIT = 65536
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [3:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire [7:0] o_reg_rdata,
    input wire o_reg_rvalid,
    input wire i_acc_wait,
    input wire o_inter_byte_delay_en,
    input wire o_timeout_detect_off,
    input wire [2:0] o_guard_time_sel,
    input wire [7:0] o_guard_cycles,
    input wire [1:0] o_idle_chars,
    input wire o_timeout_err,
    input wire o_system_reset
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [19:0] run;
    always @(posedge i_clk) begin
        if (i_rst || !i_acc_wait) begin
            run <= 20'h0_0000;
        end else if (run != 20'hF_FFFF) begin
            run <= run + 20'h0_0001;
        end
    end
    default clocking dcb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////
    chk_guard_map: assert property (
        o_guard_cycles == ((o_guard_time_sel == 3'h7) ? 8'h00 : (8'h80 >> o_guard_time_sel)))
        else $error("guard cycles wrong");
    chk_read_answer: assert property (
        o_reg_rvalid == $past(i_reg_rd)) else $error("read answer timing wrong");
    chk_rdata_idle: assert property (
        !o_reg_rvalid |-> o_reg_rdata == 8'h00) else $error("read data not idle");
    chk_unmapped_zero: assert property (
        i_reg_rd && (i_reg_addr inside {[4'h4:4'h6], [4'hA:4'hF]}) |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rev_field: assert property (
        i_reg_rd && i_reg_addr == 4'h0 |=> o_reg_rdata == {IMPL_REVISION, 4'h0})
        else $error("revision read wrong");
    chk_rst_set: assert property (
        i_reg_wr && i_reg_addr == 4'h8 && i_reg_wdata == 8'h59 |-> ##2 o_system_reset)
        else $error("system reset not raised");
    chk_rst_release: assert property (
        i_reg_wr && i_reg_addr == 4'h8 && i_reg_wdata != 8'h59 |-> ##2 !o_system_reset)
        else $error("system reset not released");
    chk_rst_read: assert property (
        i_reg_rd && i_reg_addr == 4'h8 |=> o_reg_rdata[7:1] == 7'h00)
        else $error("reset request upper bits set");
    chk_idle_chars: assert property (
        !o_inter_byte_delay_en && $past(!o_inter_byte_delay_en) |-> o_idle_chars == 2'h0)
        else $error("idle chars without delay enable");
    chk_timeout_wait: assert property (
        $rose(o_timeout_err) |-> $past(run, 2) >= TIMEOUT_LIMIT - 2)
        else $error("timeout too early");
    chk_timeout_off: assert property (
        o_timeout_detect_off && $past(o_timeout_detect_off, 3) |-> !o_timeout_err)
        else $error("timeout while disabled");
endmodule

// >>> debugger_model.sv
// Debugger model issuing register reads and writes
module debugger_model (
    input wire i_clk,
    input wire [7:0] i_rdata,
    input wire i_rvalid,
    output logic o_wr,
    output logic o_rd,
    output logic [3:0] o_addr,
    output logic [7:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 4'h0;
        o_wdata = 8'h00;
    end
    // Serial port is the only path in; read data is sampled one clock after the read is raised
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(negedge i_clk);
        o_wr = 1'b1;
        o_addr = a;
        o_wdata = v;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_wdata = ~v;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(negedge i_clk);
        o_rd = 1'b1;
        o_addr = a;
        @(negedge i_clk);
        v = i_rvalid ? i_rdata : 8'hxx;
        o_rd = 1'b0;
        o_addr = ~a;
    endtask
endmodule

// >>> debug_port_control_registers_tb.sv
// Self-checking bench for the debug port register bank
module debug_port_control_registers_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIM = 16;
    localparam logic [3:0] REV = 4'h5;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_acc_wait = 1'b0;
    logic i_tx_first_byte = 1'b0;
    logic i_sys_reset_during_access = 1'b0;
    logic [9:0] ev = 10'h000;
    logic i_reg_wr, i_reg_rd, o_reg_rvalid, o_inter_byte_delay_en, o_parity_check_off;
    logic o_timeout_detect_off, o_response_sig_off, o_neg_ack_en, o_contention_detect_off;
    logic o_timeout_err, o_system_reset, o_interface_reset, o_clock_request;
    logic [3:0] i_reg_addr;
    logic [7:0] i_reg_wdata, o_reg_rdata, o_guard_cycles, d;
    logic [2:0] o_guard_time_sel;
    logic [1:0] o_idle_chars, o_link_clock_select;
    int err_total = 0, total_checks = 0, cycles = 0, tcnt = 0, i, n;
    integer seed;
    logic [3:0] ra [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'h4, 4'hA};
    logic [7:0] rv [9] = '{{REV, 4'h0}, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
    logic [7:0] ec [4] = '{8'h01, 8'h02, 8'h04, 8'h07};
    debug_port_control_registers #(.IMPL_REVISION(REV), .TIMEOUT_LIMIT(LIM)) dut (
        .i_clk, .i_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
        .o_reg_rvalid, .i_err_parity(ev[0]), .i_err_frame(ev[1]),
        .i_err_clock_recovery(ev[2]), .i_err_contention(ev[3]), .i_acc_wait,
        .i_tx_first_byte, .i_sys_reset_during_access, .i_user_row_key_set(ev[4]),
        .i_user_row_key_clr(ev[5]), .i_program_key_set(ev[6]), .i_program_done(ev[7]),
        .i_erase_key_set(ev[8]), .i_erase_done(ev[9]), .o_inter_byte_delay_en,
        .o_parity_check_off, .o_timeout_detect_off, .o_response_sig_off, .o_guard_time_sel,
        .o_guard_cycles, .o_idle_chars, .o_neg_ack_en, .o_contention_detect_off,
        .o_link_clock_select, .o_interface_reset, .o_clock_request, .o_timeout_err,
        .o_system_reset);
    debugger_model dbg (.i_clk, .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid),
        .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (o_timeout_err === 1'b1) tcnt <= tcnt + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        dbg.rd(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge i_clk);
    endtask
    task automatic pulse(input int k);
        @(negedge i_clk);
        ev[k] = 1'b1;
        @(negedge i_clk);
        ev[k] = 1'b0;
    endtask
    function automatic logic [7:0] gexp(input logic [2:0] s);
        return (s == 3'h7) ? 8'h00 : (8'h80 >> s);
    endfunction
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h379f;
        cyc(3);
        i_rst = 1'b0;
        for (i = 0; i < 9; i++) rchk(ra[i], rv[i]);
        chk("clkreq", 8'h01, {7'h00, o_clock_request});
        chk("ifrst", 8'h00, {7'h00, o_interface_reset});
        dbg.wr(4'h0, 8'hFF);
        dbg.wr(4'h5, 8'hFF);
        rchk(4'h0, {REV, 4'h0});
        rchk(4'h5, 8'h00);
        for (i = 0; i < 12; i++) begin
            d = 8'($random(seed));
            d[2:0] = i[2:0];
            i_tx_first_byte = 1'($random(seed));
            dbg.wr(4'h2, d);
            cyc(2);
            chk("guard", gexp(d[2:0]), o_guard_cycles);
            chk("ctrl1", {1'b0, d[7], d[5:0]}, {1'b0, o_inter_byte_delay_en,
                o_parity_check_off, o_timeout_detect_off, o_response_sig_off,
                o_guard_time_sel});
            chk("idle", (d[7] && !i_tx_first_byte) ? 8'h02 : 8'h00, {6'h00, o_idle_chars});
            rchk(4'h2, d & 8'hBF);
        end
        i_sys_reset_during_access = 1'b1;
        for (i = 0; i < 4; i++) begin
            d = {3'h0, i[1:0], 3'h0};
            dbg.wr(4'h3, d);
            cyc(2);
            chk("nack", {7'h00, !d[4]}, {7'h00, o_neg_ack_en});
            chk("ccd", {7'h00, d[3]}, {7'h00, o_contention_detect_off});
            rchk(4'h3, d);
        end
        dbg.wr(4'h3, 8'h00);
        dbg.wr(4'h2, 8'h00);
        for (i = 0; i < 4; i++) begin
            pulse(i);
            cyc(4);
            rchk(4'h1, ec[i]);
            rchk(4'h1, 8'h00);
        end
        dbg.wr(4'h2, 8'h20);
        pulse(0);
        cyc(4);
        rchk(4'h1, 8'h00);
        dbg.wr(4'h3, 8'h08);
        pulse(3);
        cyc(4);
        rchk(4'h1, 8'h00);
        dbg.wr(4'h3, 8'h00);
        for (i = 0; i < 3; i++) begin
            dbg.wr(4'h2, (i == 1) ? 8'h10 : 8'h00);
            cyc(2);
            n = tcnt;
            i_acc_wait = 1'b1;
            cyc((i == 2) ? LIM - 4 : LIM + 6);
            i_acc_wait = 1'b0;
            cyc(2);
            chk("timeout", (i == 0) ? 8'h01 : 8'h00, 8'(tcnt - n));
            rchk(4'h1, (i == 0) ? 8'h03 : 8'h00);
        end
        pulse(4);
        pulse(6);
        pulse(8);
        rchk(4'h7, 8'h38);
        pulse(7);
        rchk(4'h7, 8'h28);
        pulse(9);
        rchk(4'h7, 8'h20);
        pulse(5);
        rchk(4'h7, 8'h00);
        dbg.wr(4'h2, 8'h85);
        dbg.wr(4'h8, 8'h59);
        cyc(2);
        chk("sysrst", 8'h01, {7'h00, o_system_reset});
        rchk(4'h8, 8'h01);
        rchk(4'h2, 8'h85);
        d = 8'($random(seed));
        if (d == 8'h59) d = 8'h00;
        dbg.wr(4'h8, d);
        cyc(2);
        chk("sysrst", 8'h00, {7'h00, o_system_reset});
        rchk(4'h8, 8'h00);
        dbg.wr(4'h9, 8'h01);
        cyc(2);
        chk("clksel", 8'h01, {6'h00, o_link_clock_select});
        dbg.wr(4'h9, 8'h00);
        rchk(4'h9, 8'h01);
        pulse(4);
        pulse(1);
        cyc(4);
        dbg.wr(4'h3, 8'h04);
        cyc(2);
        chk("ifrst", 8'h01, {7'h00, o_interface_reset});
        chk("clkreq", 8'h00, {7'h00, o_clock_request});
        cyc(1);
        for (i = 1; i < 7; i++) rchk(ra[i], rv[i]);
        chk("guard", 8'h80, o_guard_cycles);
        finish_test();
    end
endmodule
bind debug_port_control_registers debug_port_control_registers_chk #(
    .IMPL_REVISION(IMPL_REVISION), .TIMEOUT_LIMIT(TIMEOUT_LIMIT)) u_chk (
    .i_clk, .i_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .o_reg_rvalid, .i_acc_wait, .o_inter_byte_delay_en, .o_timeout_detect_off,
    .o_guard_time_sel, .o_guard_cycles, .o_idle_chars, .o_timeout_err, .o_system_reset);
